// >>> design/rdt_pkg.sv
// shared constants and types of the reload down timer
package rdt_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0]  RDT_IDX_CTRL      = 6'h19;
  localparam logic [5:0]  RDT_IDX_RELOAD_HI = 6'h1A;
  localparam logic [5:0]  RDT_IDX_RELOAD_LO = 6'h1B;
  localparam logic [5:0]  RDT_IDX_COUNT_HI  = 6'h1C;
  localparam logic [5:0]  RDT_IDX_COUNT_LO  = 6'h1D;
  localparam logic [5:0]  RDT_IDX_STATUS    = 6'h30;
  localparam logic [5:0]  RDT_IDX_CLEAR     = 6'h31;
  localparam logic [5:0]  RDT_IDX_ENABLE    = 6'h32;
  localparam logic [5:0]  RDT_IDX_COMMAND   = 6'h33;
  // control field positions
  localparam int unsigned RDT_CTL_STOP_RX   = 7;
  localparam int unsigned RDT_CTL_START_LO  = 4;
  localparam int unsigned RDT_CTL_AUTO      = 3;
  localparam int unsigned RDT_CTL_TICK_LO   = 0;
  // writable control bits, bits 6 and 2 reserved
  localparam logic [7:0]  RDT_CTL_RW_MASK   = 8'hBB;
  // reset values
  localparam logic [7:0]  RDT_CTL_RST       = 8'h00;
  localparam logic [7:0]  RDT_BYTE_RST      = 8'h00;
  localparam logic [1:0]  RDT_FLAG_RST      = 2'h0;
  // start select encodings
  localparam logic [1:0]  RDT_START_NONE    = 2'h0;
  localparam logic [1:0]  RDT_START_TX_END  = 2'h1;
  localparam logic [1:0]  RDT_START_TRIM    = 2'h2;
  localparam logic [1:0]  RDT_START_TRIM_UF = 2'h3;
  // tick source encodings
  localparam logic [1:0]  RDT_TICK_FAST     = 2'h0;
  localparam logic [1:0]  RDT_TICK_SLOW     = 2'h1;
  localparam logic [1:0]  RDT_TICK_TIMER0   = 2'h2;
  localparam logic [1:0]  RDT_TICK_TIMER1   = 2'h3;
  // status, clear, enable bit positions
  localparam int unsigned RDT_ST_UNDERFLOW  = 0;
  localparam int unsigned RDT_ST_TRIM_DONE  = 1;
  // command bit positions
  localparam int unsigned RDT_CMD_START     = 0;
  localparam int unsigned RDT_CMD_STOP      = 1;
  // rates in Hz; tick dividers are derived from them
  localparam int unsigned RDT_CLK_HZ        = 250_000_000;
  localparam int unsigned RDT_FAST_HZ       = 13_560_000;
  localparam int unsigned RDT_SLOW_HZ       = 212_000;
  // counting state
  typedef enum logic {RDT_IDLE, RDT_COUNT} rdt_state_t;
endpackage : rdt_pkg

// >>> design/rdt_sync2.sv
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module rdt_sync2
  import rdt_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_reg; // first stage, read only by the second

  // plain two-stage chain
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_reg <= 1'b0;
      sync_o   <= 1'b0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule : rdt_sync2

// >>> design/rdt_frac_div.sv
// fractional rate divider giving one-cycle tick pulses
`timescale 1ns/1ps
module rdt_frac_div
  import rdt_pkg::*;
#(
  parameter int unsigned ACC_W  = 28,
  parameter int unsigned OUT_HZ = RDT_FAST_HZ,
  parameter int unsigned IN_HZ  = RDT_CLK_HZ
)
(
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  output logic      tick_o
);
  localparam logic [ACC_W:0] INC = (ACC_W+1)'(OUT_HZ); // step per clock
  localparam logic [ACC_W:0] MOD = (ACC_W+1)'(IN_HZ);  // wrap point

  logic [ACC_W-1:0] acc_reg; // phase accumulator
  logic [ACC_W:0]   sum;     // one bit wider, no overflow
  logic             wrap;    // phase passed a whole period

  // average rate exact, jitter of one clock accepted
  assign sum  = {1'b0, acc_reg} + INC;
  assign wrap = (sum >= MOD);

  // accumulate and emit a pulse on wrap
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      acc_reg <= '0;
      tick_o  <= 1'b0;
    end
    else
    begin
      acc_reg <= wrap ? ACC_W'(sum - MOD) : ACC_W'(sum);
      tick_o  <= wrap;
    end
  end
endmodule : rdt_frac_div

// >>> design/rdt_timer.sv
// third reload down timer: registers, start/stop control and counter
`timescale 1ns/1ps
// Notes on behaviour
// - stop bit halts timer after first four bits
// - trimming modes ignore the stop bit
// - start select 00b never auto-starts
// - start select 01b starts at transmit end
// - 10b trims oscillator, no underflow, edge start/stop
// - 11b trims oscillator, underflow allowed, edge start/stop
// - auto restart reloads at zero and continues
// - without auto restart counter stops at zero
// - every underflow sets the interrupt flag
// - tick 00b fast clock, 01b slow clock
// - tick 10b, 11b sibling timer underflows
// - start loads counter from both reload bytes
// - reload writes never disturb a running count
// - registers at 19h, 1Ah, 1Bh; bits 6,2 reserved
module rdt_timer
  import rdt_pkg::*;
#(
  parameter int unsigned CNT_W = 16
)
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        tx_end_i,
  input  wire logic        rx_first_bits_i,
  input  wire logic        slow_oscillator_i,
  input  wire logic        timer0_underflow_i,
  input  wire logic        timer1_underflow_i,
  output logic             underflow_o,
  output logic             running_o,
  output logic             irq_o
);
  // register storage
  logic [7:0]       ctrl_reg;       // timer_two_control
  logic [7:0]       reload_hi_reg;  // timer_two_reload_high
  logic [7:0]       reload_lo_reg;  // timer_two_reload_low
  logic [1:0]       status_reg;     // sticky event flags
  logic [1:0]       enable_reg;     // interrupt enables
  logic             ack_reg;        // bus answer phase
  logic [CNT_W-1:0] count_reg;      // current count
  logic [CNT_W-1:0] count_next;
  rdt_state_t       state_reg;      // idle or counting
  rdt_state_t       state_next;
  logic             osc_last_reg;   // previous synced oscillator level

  // bus decode
  wire        req       = avs_read_i | avs_write_i;
  wire        wr_ok     = avs_write_i & ack_reg & avs_byteenable_i[0];
  wire        sel_ctrl  = (avs_address_i == RDT_IDX_CTRL);
  wire        sel_rhi   = (avs_address_i == RDT_IDX_RELOAD_HI);
  wire        sel_rlo   = (avs_address_i == RDT_IDX_RELOAD_LO);
  wire        sel_chi   = (avs_address_i == RDT_IDX_COUNT_HI);
  wire        sel_clo   = (avs_address_i == RDT_IDX_COUNT_LO);
  wire        sel_stat  = (avs_address_i == RDT_IDX_STATUS);
  wire        sel_clr   = (avs_address_i == RDT_IDX_CLEAR);
  wire        sel_en    = (avs_address_i == RDT_IDX_ENABLE);
  wire        sel_cmd   = (avs_address_i == RDT_IDX_COMMAND);
  wire [7:0]  wbyte     = avs_writedata_i[7:0];

  // control fields
  wire        stop_rx_bit  = ctrl_reg[RDT_CTL_STOP_RX];
  wire [1:0]  start_select = ctrl_reg[RDT_CTL_START_LO +: 2];
  wire        auto_restart = ctrl_reg[RDT_CTL_AUTO];
  wire [1:0]  tick_select  = ctrl_reg[RDT_CTL_TICK_LO +: 2];
  wire        trim_mode    = start_select[1];
  wire        trim_no_uf   = (start_select == RDT_START_TRIM);
  wire [CNT_W-1:0] reload_value = {reload_hi_reg, reload_lo_reg};
  wire        counting     = (state_reg == RDT_COUNT);

  // tick sources
  logic fast_tick; // 13.56 MHz enable
  logic slow_tick; // 212 kHz enable
  logic osc_sync;  // synced slow oscillator

  rdt_frac_div #(
    .ACC_W  (28),
    .OUT_HZ (RDT_FAST_HZ),
    .IN_HZ  (RDT_CLK_HZ)
  ) u_fast_div (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .tick_o    (fast_tick)
  );

  rdt_frac_div #(
    .ACC_W  (28),
    .OUT_HZ (RDT_SLOW_HZ),
    .IN_HZ  (RDT_CLK_HZ)
  ) u_slow_div (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .tick_o    (slow_tick)
  );

  // oscillator pin comes from outside the clock domain
  rdt_sync2 u_osc_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (slow_oscillator_i),
    .sync_o    (osc_sync)
  );

  // tick source multiplexer
  wire tick_src_fast = (tick_select == RDT_TICK_FAST)   & fast_tick;
  wire tick_src_slow = (tick_select == RDT_TICK_SLOW)   & slow_tick;
  wire tick_src_t0   = (tick_select == RDT_TICK_TIMER0) & timer0_underflow_i;
  wire tick_src_t1   = (tick_select == RDT_TICK_TIMER1) & timer1_underflow_i;
  wire tick = tick_src_fast | tick_src_slow | tick_src_t0 | tick_src_t1;

  // oscillator rising edge, read from the second sync stage only
  wire osc_rise = osc_sync & ~osc_last_reg;

  // software commands take effect with the write
  wire cmd_wr   = wr_ok & sel_cmd;
  wire sw_start = cmd_wr & wbyte[RDT_CMD_START];
  wire sw_stop  = cmd_wr & wbyte[RDT_CMD_STOP];

  // trimming: first edge starts, the next edge stops
  wire trim_start = trim_mode & osc_rise & ~counting;
  wire trim_stop  = trim_mode & osc_rise & counting;

  // reception stop, masked in trimming modes
  wire rx_stop = stop_rx_bit & ~trim_mode & rx_first_bits_i;

  // transmit-end start only in mode 01b; mode 00b has none
  wire tx_start = (start_select == RDT_START_TX_END) & tx_end_i;

  // a stop in the same cycle as a start wins
  wire start_evt = sw_start | tx_start | trim_start;
  wire stop_evt  = sw_stop | rx_stop | trim_stop;

  // step from zero, suppressed in trimming without underflow
  wire at_zero = (count_reg == '0);
  wire uf_now  = counting & tick & at_zero & ~trim_no_uf
                 & ~stop_evt & ~start_evt;

  // counter and state next values
  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    unique case (state_reg)
      RDT_IDLE:
      begin
        // load from both reload bytes on start
        if (start_evt && !stop_evt)
        begin
          state_next = RDT_COUNT;
          count_next = reload_value;
        end
      end
      RDT_COUNT:
      begin
        if (stop_evt)
        begin
          state_next = RDT_IDLE;
        end
        else if (start_evt)
        begin
          count_next = reload_value;
        end
        else if (tick)
        begin
          if (!at_zero)
          begin
            count_next = count_reg - CNT_W'(1);
          end
          else if (trim_no_uf)
          begin
            count_next = count_reg; // held at zero
          end
          else if (auto_restart)
          begin
            count_next = reload_value;
          end
          else
          begin
            state_next = RDT_IDLE;
          end
        end
      end
    endcase
  end

  // counter and state; reload bytes only act through a start or an auto restart reload
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= RDT_IDLE;
      count_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // edge memory and event outputs
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      osc_last_reg <= 1'b0;
      underflow_o  <= 1'b0;
    end
    else
    begin
      osc_last_reg <= osc_sync;
      underflow_o  <= uf_now;
    end
  end

  assign running_o = counting;

  // one wait cycle, then the answer; write lands on the release edge
  assign avs_waitrequest_o = req & ~ack_reg;

  // configuration registers
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_reg      <= RDT_CTL_RST;
      reload_hi_reg <= RDT_BYTE_RST;
      reload_lo_reg <= RDT_BYTE_RST;
      enable_reg    <= RDT_FLAG_RST;
    end
    else if (wr_ok)
    begin
      // reserved control bits stay zero
      if (sel_ctrl)
        ctrl_reg <= wbyte & RDT_CTL_RW_MASK;
      if (sel_rhi)
        reload_hi_reg <= wbyte;
      if (sel_rlo)
        reload_lo_reg <= wbyte;
      if (sel_en)
        enable_reg <= wbyte[1:0];
    end
  end

  // sticky flags: a set in the clearing cycle survives
  wire [1:0] set_bits = {trim_stop, uf_now};
  wire [1:0] clr_bits = (wr_ok & sel_clr) ? wbyte[1:0] : 2'h0;
  wire [1:0] status_next = (status_reg & ~clr_bits) | set_bits;

  // status flags
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      status_reg <= RDT_FLAG_RST;
    else
      status_reg <= status_next;
  end

  assign irq_o = |(status_reg & enable_reg);

  // read multiplexer; unmapped and write-only read zero
  // count readback is not frozen, so a read mid-reception may tear
  wire [7:0] rd_byte =
    sel_ctrl ? ctrl_reg :
    sel_rhi  ? reload_hi_reg :
    sel_rlo  ? reload_lo_reg :
    sel_chi  ? count_reg[15:8] :
    sel_clo  ? count_reg[7:0] :
    sel_stat ? {5'h00, counting, status_reg} :
    sel_en   ? {6'h00, enable_reg} : 8'h00;

  // answer phase and read data
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack_reg        <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end
    else
    begin
      ack_reg <= req & ~ack_reg;
      if (avs_read_i && !ack_reg)
        avs_readdata_o <= {24'h000000, rd_byte};
    end
  end

  // checks on the counting logic
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_start_loads_reload:
    assert property (start_evt && !stop_evt |=> counting
                     && count_reg == $past(reload_value))
    else $error("start did not load reload value");

  a_underflow_sets_flag:
    assert property (uf_now |=> status_reg[RDT_ST_UNDERFLOW] ##0 underflow_o)
    else $error("underflow flag not set");

  a_rx_stops_timer:
    assert property (counting && rx_stop |=> !counting)
    else $error("reception did not stop timer");

  a_trim_ignores_rx:
    assert property (counting && trim_mode && rx_first_bits_i && !osc_rise
                     && !sw_stop && !(tick && at_zero) |=> counting)
    else $error("reception stopped a trimming count");

  a_no_auto_start:
    assert property (!counting && start_select == RDT_START_NONE
                     && !sw_start |=> !counting)
    else $error("timer started with start select 00b");

  a_tx_end_starts:
    assert property (!counting && start_select == RDT_START_TX_END && tx_end_i
                     && !stop_evt |=> counting)
    else $error("transmit end did not start timer");

  a_trim_holds_zero:
    assert property (counting && trim_no_uf && at_zero && !osc_rise && !sw_stop
                     && !sw_start |=> counting && at_zero && !underflow_o)
    else $error("trimming without underflow left zero");

  a_trim_edge_stops:
    assert property (counting && trim_mode && osc_rise && !sw_start
                     |=> !counting ##0 status_reg[RDT_ST_TRIM_DONE])
    else $error("second oscillator edge did not stop");

  a_auto_reloads:
    assert property (uf_now && auto_restart |=> counting
                     && count_reg == $past(reload_value))
    else $error("auto restart did not reload");

  a_stop_at_zero:
    assert property (uf_now && !auto_restart |=> !counting && at_zero)
    else $error("counter did not stop at zero");

  a_count_steps_down:
    assert property (counting && tick && !at_zero && !start_evt && !stop_evt
                     |=> count_reg == $past(count_reg) - CNT_W'(1))
    else $error("counter did not step down by one");

  a_reload_write_quiet:
    assert property (counting && !tick && !start_evt && !stop_evt
                     |=> $stable(count_reg))
    else $error("count changed without tick");

endmodule : rdt_timer

// >>> tb/rdt_timer_bench.sv
// self-checking bench of the third reload down timer
`timescale 1ns/1ps
module rdt_timer_bench;
  import rdt_pkg::*;
  logic        clk_i     = 1'b0;  // 250 MHz system clock
  logic        reset_n_i = 1'b0;  // async reset, active low
  logic [5:0]  adr       = 6'h00; // register index
  logic        rd        = 1'b0;  // read request
  logic        wr        = 1'b0;  // write request
  logic [31:0] wdat      = 32'h0; // write data
  logic [3:0]  ev        = 4'h0;  // tx end, rx bits, timer0, timer1 pulses
  logic        osc       = 1'b0;  // slow oscillator level
  logic [31:0] rdat;              // read data
  logic        wreq;              // waitrequest
  logic        uf;                // underflow pulse
  logic        run;               // counting level
  logic        irq;               // interrupt level
  int          failures    = 0;   // mismatches
  int          checks_done = 0;   // comparisons
  int          uf_cnt      = 0;   // underflow pulses seen
  logic [7:0]  r8;                // last byte read
  logic [15:0] c16;               // last count read

  // half period of 2 ns
  always #2 clk_i = ~clk_i;

  // count pulses so no single-cycle pulse is missed
  always @(posedge clk_i)
    if (uf === 1'b1)
      uf_cnt <= uf_cnt + 1;

  rdt_timer dut_u (
    .clk_i              (clk_i),
    .reset_n_i          (reset_n_i),
    .avs_address_i      (adr),
    .avs_read_i         (rd),
    .avs_write_i        (wr),
    .avs_writedata_i    (wdat),
    .avs_byteenable_i   (4'h1),
    .avs_readdata_o     (rdat),
    .avs_waitrequest_o  (wreq),
    .tx_end_i           (ev[0]),
    .rx_first_bits_i    (ev[1]),
    .slow_oscillator_i  (osc),
    .timer0_underflow_i (ev[2]),
    .timer1_underflow_i (ev[3]),
    .underflow_o        (uf),
    .running_o          (run),
    .irq_o              (irq)
  );

  // verdict and end of run
  task automatic end_sim;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // compare seen against expected
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one bus cycle; held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    adr  <= a;
    wdat <= {24'h0, d};
    rd   <= ~w;
    wr   <= w;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    // data taken and request released at the edge that samples the answer
    r8 = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
    begin
      failures++;
      end_sim;
    end
  endtask : bus

  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr8

  task automatic rd8(input logic [5:0] a);
    bus(1'b0, a, 8'h00);
  endtask : rd8

  // live count may tear, but only bench pulses tick here
  task automatic rdcnt;
    rd8(RDT_IDX_COUNT_HI);
    c16[15:8] = r8;
    rd8(RDT_IDX_COUNT_LO);
    c16[7:0] = r8;
  endtask : rdcnt

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  // n one-cycle pulses on event line k, a gap after each
  task automatic pulse(input int k, input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      ev[k] <= 1'b1;
      @(posedge clk_i);
      ev[k] <= 1'b0;
    end
  endtask : pulse

  // oscillator level; the sync chain needs a few cycles
  task automatic osc_set(input logic v);
    @(posedge clk_i);
    osc <= v;
    cyc(8);
  endtask : osc_set

  // start at transmit end, count cycles up to the underflow
  task automatic tmeas(input int lo, input int hi);
    int n;
    int u;
    n = 0;
    u = uf_cnt;
    pulse(0, 1);
    while (uf_cnt == u && n < 6000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h0001);
    // a wait that used up its bound ends the run
    if (n >= 6000)
    begin
      failures++;
      end_sim;
    end
  endtask : tmeas

  // hang guard, 50k cycles, well under the 100k budget
  initial
  begin
    #200000;
    failures++;
    end_sim;
  end

  // main sequence
  initial
  begin
    int u;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // registers, reserved bits, unmapped index
    rd8(RDT_IDX_CTRL);
    chk(r8, 8'h00);
    wr8(RDT_IDX_CTRL, 8'hFF);
    rd8(RDT_IDX_CTRL);
    chk(r8, 8'hBB);
    wr8(RDT_IDX_RELOAD_HI, 8'hA5);
    rd8(RDT_IDX_RELOAD_HI);
    chk(r8, 8'hA5);
    wr8(RDT_IDX_RELOAD_LO, 8'h5A);
    rd8(RDT_IDX_RELOAD_LO);
    chk(r8, 8'h5A);
    rd8(6'h3F);
    chk(r8, 8'h00);
    $display("test registers done");
    // fast tick, 17 ticks of about 18.4 cycles
    wr8(RDT_IDX_RELOAD_HI, 8'h00);
    wr8(RDT_IDX_RELOAD_LO, 8'h10);
    wr8(RDT_IDX_ENABLE, 8'h01);
    wr8(RDT_IDX_CTRL, 8'h10);
    tmeas(280, 345);
    chk(run, 1'b0);
    chk(irq, 1'b1);
    rdcnt;
    chk(c16, 16'h0000);
    wr8(RDT_IDX_ENABLE, 8'h00);
    cyc(1);
    chk(irq, 1'b0);
    wr8(RDT_IDX_CLEAR, 8'h01);
    rd8(RDT_IDX_STATUS);
    chk(r8, 8'h00);
    // slow tick, 3 ticks of about 1179 cycles
    wr8(RDT_IDX_RELOAD_LO, 8'h02);
    wr8(RDT_IDX_CTRL, 8'h11);
    tmeas(2350, 3600);
    $display("test tick clocks done");
    // sibling underflow ticks, mode 00b, reload writes
    wr8(RDT_IDX_RELOAD_HI, 8'h01);
    wr8(RDT_IDX_RELOAD_LO, 8'h00);
    wr8(RDT_IDX_CTRL, 8'h02);
    pulse(0, 1);
    cyc(2);
    chk(run, 1'b0);
    wr8(RDT_IDX_COMMAND, 8'h01);
    cyc(2);
    chk(run, 1'b1);
    pulse(2, 5);
    rdcnt;
    chk(c16, 16'h00FB);
    pulse(3, 3);
    rdcnt;
    chk(c16, 16'h00FB);
    wr8(RDT_IDX_RELOAD_HI, 8'h00);
    wr8(RDT_IDX_RELOAD_LO, 8'h20);
    rdcnt;
    chk(c16, 16'h00FB);
    wr8(RDT_IDX_COMMAND, 8'h01);
    cyc(2);
    rdcnt;
    chk(c16, 16'h0020);
    wr8(RDT_IDX_CTRL, 8'h82);
    pulse(1, 1);
    cyc(2);
    chk(run, 1'b0);
    $display("test sources done");
    // auto restart on timer1 ticks
    wr8(RDT_IDX_RELOAD_LO, 8'h02);
    wr8(RDT_IDX_CTRL, 8'h0B);
    wr8(RDT_IDX_COMMAND, 8'h01);
    cyc(2);
    u = uf_cnt;
    pulse(3, 3);
    cyc(2);
    chk(16'(uf_cnt - u), 16'h0001);
    chk(run, 1'b1);
    rdcnt;
    chk(c16, 16'h0002);
    wr8(RDT_IDX_COMMAND, 8'h02);
    $display("test auto restart done");
    // trimming without underflow, stop bit ignored
    wr8(RDT_IDX_RELOAD_LO, 8'h01);
    wr8(RDT_IDX_CTRL, 8'hA3);
    osc_set(1'b1);
    chk(run, 1'b1);
    pulse(1, 1);
    cyc(2);
    chk(run, 1'b1);
    u = uf_cnt;
    pulse(3, 3);
    cyc(2);
    chk(16'(uf_cnt - u), 16'h0000);
    rdcnt;
    chk(c16, 16'h0000);
    osc_set(1'b0);
    osc_set(1'b1);
    chk(run, 1'b0);
    // stopping edge sets trim done; underflow flag left from auto restart
    rd8(RDT_IDX_STATUS);
    chk(r8, 8'h03);
    // trimming with underflow
    osc_set(1'b0);
    wr8(RDT_IDX_CTRL, 8'hB3);
    osc_set(1'b1);
    chk(run, 1'b1);
    pulse(1, 1);
    cyc(2);
    chk(run, 1'b1);
    u = uf_cnt;
    pulse(3, 2);
    cyc(2);
    chk(16'(uf_cnt - u), 16'h0001);
    $display("test trimming done");
    end_sim;
  end
endmodule : rdt_timer_bench
